// ---- bldc_params.svh ----
/*
  Constants for the speed-loop block: timing, scaling and limits.
  Assumes a 20 MHz system clock.
*/
`ifndef BLDC_PARAMS_SVH
`define BLDC_PARAMS_SVH

`define CLK_MHZ 20
`define SAMPLE_US 1000
`define SAMPLE_CYC (`SAMPLE_US * `CLK_MHZ)
`define EDGE_TIMEOUT_US 100000
`define EDGE_TIMEOUT_CYC (`EDGE_TIMEOUT_US * `CLK_MHZ)
`define PWM_PERIOD 12'd1000
`define DUTY_MAX 12'sd1000
`define ALIGN_DUTY 12'd200
`define RAMP_STEP 16'sd4
`define SPEED_MIN 16'sd1
`define SPEED_MAX 16'sd100
`define GAIN_SHIFT 8

`endif

// ---- bldc_pkg.sv ----
/*
  Types shared by the speed-loop block and its bench.
  Assumes nothing beyond a SystemVerilog tool.
*/
package bldc_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ALIGN = 2'b01,
    ST_RUN = 2'b10,
    ST_TRIP = 2'b11
  } ctrl_state_e;

  typedef struct packed {
    logic a;
    logic b;
    logic idx;
  } enc_pins_s;

  typedef struct packed {
    logic [15:0] kc;
    logic [15:0] ki;
  } pi_gains_s;

  typedef struct packed {
    logic [2:0] high_side;
    logic [2:0] low_side;
  } phase_drive_s;
endpackage

// ---- bldc_speed_pi_loop.sv ----
/*
  Brushless motor speed loop: quadrature decoder, speed measurement, ramp,
  PI law, six-output PWM with commutation and over-current cut-off.
  Assumes the host sets the sector and compares, and that encoder, run switch
  and over-current arrive asynchronously from pins.
*/
`include "bldc_params.svh"

// What this block does
// - Error is ramp speed minus measured speed
// - Proportional plus accumulated integral term
// - PI output becomes the PWM duty
// - Host speed request passes a ramp
// - Speed from position and last edge time
// - Interrupt when position hits sector border
// - Over-current cuts PWM; host latches off
// - Over-current onset interrupts the host
// - Six PWM outputs, pair per phase
// - Three encoder inputs: A, B, index
// - Run switch off disables all phases
// - Both directions, four-quadrant drive
// - Required speed limited between min and max
// - Rotor aligned before first start
// - Load compares, zero counter, then arm
module bldc_speed_pi_loop #(
  parameter int SAMPLE_CYCLES = `SAMPLE_CYC,
  parameter int EDGE_TIMEOUT = `EDGE_TIMEOUT_CYC
) (
  input wire logic clk,
  input wire logic rst,
  input wire bldc_pkg::enc_pins_s enc,
  input wire logic overcurrent_pin,
  input wire logic run_switch_pin,
  input wire logic signed [15:0] speed_required,
  input wire bldc_pkg::pi_gains_s gains,
  input wire logic [2:0] sector,
  input wire logic commutate,
  input wire logic host_pwm_off,
  input wire logic align_req,
  input wire logic cmp_load,
  input wire logic pos_zero,
  input wire logic [15:0] cmp_lo,
  input wire logic [15:0] cmp_hi,
  output bldc_pkg::phase_drive_s drive,
  output logic pos_irq,
  output logic oc_irq,
  output logic index_pulse,
  output logic [15:0] position,
  output logic signed [15:0] speed_meas,
  output logic signed [11:0] duty
);
  import bldc_pkg::*;
  // encoder, switch and fault pins synchronised
  logic [4:0] pin_meta, pin_sync;
  always_ff @(posedge clk) begin
    pin_meta <= {enc.a, enc.b, enc.idx, overcurrent_pin, run_switch_pin};
    pin_sync <= pin_meta;
  end
  wire a_s = pin_sync[4];
  wire b_s = pin_sync[3];
  wire idx_s = pin_sync[2];
  wire oc_s = pin_sync[1];
  wire run_s = pin_sync[0];
  logic a_prev, b_prev, idx_prev, oc_prev;
  always_ff @(posedge clk) begin
    a_prev <= a_s;
    b_prev <= b_s;
    idx_prev <= idx_s;
    oc_prev <= oc_s;
  end
  wire enc_step = (a_s ^ a_prev) ^ (b_s ^ b_prev);
  wire enc_up = a_prev ^ b_s;
  wire [15:0] next_position = enc_up ? position + 16'd1 : position - 16'd1;
  // Compares and arming
  logic [15:0] cmp_a, cmp_b;
  logic armed;
  always_ff @(posedge clk) begin
    if (rst) begin
      cmp_a <= 16'h0000;
      cmp_b <= 16'h0000;
    end else if (cmp_load) begin
      cmp_a <= cmp_lo;
      cmp_b <= cmp_hi;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      position <= 16'h0000;
      armed <= 1'b0;
    end else if (pos_zero) begin
      position <= 16'h0000;
      armed <= 1'b1;
    end else if (enc_step) begin
      position <= next_position;
    end
  end
  wire border_hit = armed && !pos_zero && enc_step && (next_position == cmp_a || next_position == cmp_b);
  wire oc_rise = oc_s && !oc_prev;
  always_ff @(posedge clk) begin
    if (rst) begin
      pos_irq <= 1'b0;
      oc_irq <= 1'b0;
      index_pulse <= 1'b0;
    end else begin
      pos_irq <= border_hit;
      oc_irq <= oc_rise;
      index_pulse <= idx_s && !idx_prev;
    end
  end
  // Sample tick divider and free-running time base
  logic [31:0] sample_cnt, tstamp, last_edge_time;
  logic [15:0] last_edge_pos, prev_edge_pos;
  wire tick = (sample_cnt == 32'(SAMPLE_CYCLES - 1));
  wire [31:0] edge_age = tstamp - last_edge_time;
  wire stale = edge_age > 32'(EDGE_TIMEOUT);
  always_ff @(posedge clk) begin
    if (rst) begin
      sample_cnt <= 32'h0;
      tstamp <= 32'h0;
    end else begin
      sample_cnt <= tick ? 32'h0 : sample_cnt + 32'h1;
      tstamp <= tstamp + 32'h1;
    end
  end
  // speed from edge position and edge time
  always_ff @(posedge clk) begin
    if (rst) begin
      last_edge_time <= 32'h0;
      last_edge_pos <= 16'h0000;
      prev_edge_pos <= 16'h0000;
      speed_meas <= 16'sh0000;
    end else begin
      if (enc_step) begin
        last_edge_time <= tstamp;
        last_edge_pos <= pos_zero ? 16'h0000 : next_position;
      end else if (pos_zero) begin
        last_edge_pos <= 16'h0000;
      end
      if (tick) begin
        prev_edge_pos <= last_edge_pos;
        speed_meas <= stale ? 16'sh0000 : $signed(last_edge_pos - prev_edge_pos);
      end
    end
  end
  wire signed [15:0] req_mag = speed_required < 0 ? -speed_required : speed_required;
  wire signed [15:0] target = (req_mag < `SPEED_MIN) ? 16'sh0000 :
    (speed_required > `SPEED_MAX) ? `SPEED_MAX :
    (speed_required < -`SPEED_MAX) ? -`SPEED_MAX : speed_required;
  logic signed [15:0] ramp;
  wire signed [16:0] ramp_diff = 17'(target) - 17'(ramp);
  wire signed [15:0] next_ramp = (ramp_diff > 17'(`RAMP_STEP)) ? ramp + `RAMP_STEP :
    (ramp_diff < -17'(`RAMP_STEP)) ? ramp - `RAMP_STEP : target;
  function automatic logic signed [11:0] sat_duty(input logic signed [33:0] v);
    if (v > 34'(`DUTY_MAX))
      return `DUTY_MAX;
    else if (v < -34'(`DUTY_MAX))
      return -`DUTY_MAX;
    else
      return v[11:0];
  endfunction
  wire signed [16:0] err = 17'(ramp) - 17'(speed_meas);
  wire signed [33:0] prod_p = $signed({1'b0, gains.kc}) * err;
  wire signed [33:0] prod_i = $signed({1'b0, gains.ki}) * err;
  logic signed [11:0] integ;
  wire signed [11:0] next_integ = sat_duty(34'(integ) + (prod_i >>> `GAIN_SHIFT));
  wire signed [11:0] pi_out = sat_duty((prod_p >>> `GAIN_SHIFT) + 34'(next_integ));

  ctrl_state_e state, next_state;
  logic aligned;

  // alignment before first run; trip on over-current
  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (run_s && aligned)
          next_state = ST_RUN;
        else if (run_s && align_req)
          next_state = ST_ALIGN;
      end
      ST_ALIGN: begin
        if (pos_zero)
          next_state = ST_RUN;
      end
      ST_RUN: next_state = ST_RUN;
      ST_TRIP: begin
        if (!oc_s)
          next_state = ST_IDLE;
      end
      default: next_state = ST_IDLE;
    endcase
    if (!run_s)
      next_state = ST_IDLE;
    if (oc_s)
      next_state = ST_TRIP;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      aligned <= 1'b0;
    end else begin
      state <= next_state;
      if (state == ST_ALIGN && pos_zero)
        aligned <= 1'b1;
    end
  end
  // PI output loaded as duty each sample
  always_ff @(posedge clk) begin
    if (rst || state != ST_RUN) begin
      ramp <= 16'sh0000;
      integ <= 12'sh000;
      duty <= 12'sh000;
    end else if (tick) begin
      ramp <= next_ramp;
      integ <= next_integ;
      duty <= pi_out;
    end
  end
  logic [2:0] sector_q;
  always_ff @(posedge clk) begin
    if (rst)
      sector_q <= 3'd0;
    else if (commutate && sector < 3'd6)
      sector_q <= sector;
  end

  logic [11:0] pwm_cnt;
  always_ff @(posedge clk) begin
    if (rst || pwm_cnt == `PWM_PERIOD - 12'd1)
      pwm_cnt <= 12'h000;
    else
      pwm_cnt <= pwm_cnt + 12'h001;
  end

  // Sector to phase pattern: bit0 A, bit1 B, bit2 C
  wire [2:0] sec_hi = (sector_q < 3'd2) ? 3'b001 : (sector_q < 3'd4) ? 3'b010 : 3'b100;
  wire [2:0] sec_lo = (sector_q == 3'd0 || sector_q == 3'd5) ? 3'b010 :
    (sector_q == 3'd1 || sector_q == 3'd2) ? 3'b100 : 3'b001;
  wire align_on = (state == ST_ALIGN);
  wire run_on = (state == ST_RUN) && !host_pwm_off;
  wire reverse = duty < 0;
  wire [11:0] duty_mag = reverse ? 12'(-duty) : 12'(duty);
  wire pwm_on = align_on ? (pwm_cnt < `ALIGN_DUTY) : (pwm_cnt < duty_mag);
  wire [2:0] pat_hi = align_on ? 3'b001 : (reverse ? sec_lo : sec_hi);
  wire [2:0] pat_lo = align_on ? 3'b110 : (reverse ? sec_hi : sec_lo);
  wire drive_en = (align_on || run_on) && !oc_s && run_s;

  wire [2:0] next_hi, next_lo;
  genvar ph;
  generate
    for (ph = 0; ph < 3; ph++) begin : g_phase
      assign next_hi[ph] = drive_en && pat_hi[ph] && pwm_on;
      assign next_lo[ph] = drive_en && pat_lo[ph];
    end
  endgenerate
  always_ff @(posedge clk) begin
    drive <= rst ? 6'h00 : {next_hi, next_lo};
  end

  AST_SWITCH_OFF: assert property (@(posedge clk) disable iff (rst)
    !run_s |-> ##1 (drive == '0)) else $error("Phases driven while switch off");
  AST_OC_CUT: assert property (@(posedge clk) disable iff (rst)
    oc_s |-> ##1 (drive == '0) ##1 (drive == '0)) else $error("Phases driven during over-current");
  AST_OC_IRQ: assert property (@(posedge clk) disable iff (rst)
    $rose(oc_s) |=> oc_irq ##1 !oc_irq) else $error("Over-current interrupt missing");
  AST_POS_IRQ: assert property (@(posedge clk) disable iff (rst)
    pos_irq |-> (position == $past(cmp_a) || position == $past(cmp_b))) else $error("Position interrupt off border");
  AST_UNARMED: assert property (@(posedge clk) disable iff (rst)
    !armed |=> !pos_irq) else $error("Position interrupt before arming");
  AST_POS_ZERO: assert property (@(posedge clk) disable iff (rst)
    pos_zero |=> (position == 16'h0000) && armed) else $error("Counter not cleared");
  AST_DUTY_RANGE: assert property (@(posedge clk) disable iff (rst)
    (duty <= `DUTY_MAX) && (duty >= -`DUTY_MAX)) else $error("Duty out of range");
  AST_DUTY_LOAD: assert property (@(posedge clk) disable iff (rst)
    (tick && state == ST_RUN) |=> duty == $past(pi_out)) else $error("Duty not taken from controller");
  AST_RAMP_STEP: assert property (@(posedge clk) disable iff (rst)
    (state == ST_RUN && $past(state) == ST_RUN) |-> (17'(ramp) - 17'($past(ramp)) <= 17'(`RAMP_STEP))
      && (17'($past(ramp)) - 17'(ramp) <= 17'(`RAMP_STEP))) else $error("Ramp step too large");
  AST_STALE_SPEED: assert property (@(posedge clk) disable iff (rst)
    (tick && stale) |=> speed_meas == 16'sh0000) else $error("Stale speed not zero");
endmodule

// ---- bldc_host_model.sv ----
/*
  Host processor model for the speed loop: aligns, loads borders,
  commutates on position interrupts and latches the PWM off after faults.
  Assumes one clock shared with the block and a start level from the bench.
*/
module bldc_host_model #(
  parameter int ALIGN_CYCLES = 150,
  parameter int IRQ_LATENCY = 8,
  parameter int HALF_SECTOR = 5
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic start,
  input wire logic pos_irq,
  input wire logic oc_irq,
  input wire logic [15:0] position,
  output logic [2:0] sector,
  output logic commutate,
  output logic host_pwm_off,
  output logic align_req,
  output logic cmp_load,
  output logic pos_zero,
  output logic [15:0] cmp_lo,
  output logic [15:0] cmp_hi,
  output logic aligned
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] cnt;
  logic [7:0] oc_cnt;

  always_ff @(posedge clk) begin
    commutate <= 1'b0;
    cmp_load <= 1'b0;
    pos_zero <= 1'b0;
    if (rst) begin
      {sector, host_pwm_off, align_req, cmp_lo, cmp_hi, aligned} <= '0;
      cnt <= 8'h00;
      oc_cnt <= 8'h00;
    end else begin
      if (start && !aligned) begin
        align_req <= 1'b1;
        cnt <= cnt + 8'h01;
        if (cnt == 8'(ALIGN_CYCLES)) begin
          cmp_lo <= 16'(-HALF_SECTOR);
          cmp_hi <= 16'(HALF_SECTOR);
          {cmp_load, pos_zero, aligned} <= 3'h7;
          align_req <= 1'b0;
        end
      end
      if (pos_irq) begin
        if (position == cmp_hi) begin
          sector <= (sector == 3'h5) ? 3'h0 : sector + 3'h1;
          cmp_lo <= cmp_hi;
          cmp_hi <= cmp_hi + 16'(2 * HALF_SECTOR);
        end else begin
          sector <= (sector == 3'h0) ? 3'h5 : sector - 3'h1;
          cmp_hi <= cmp_lo;
          cmp_lo <= cmp_lo - 16'(2 * HALF_SECTOR);
        end
        {cmp_load, commutate} <= 2'h3;
      end
      if (oc_irq || (oc_cnt != 8'h00 && oc_cnt != 8'hff)) oc_cnt <= oc_cnt + 8'h01;
      if (oc_cnt == 8'(IRQ_LATENCY)) host_pwm_off <= 1'b1;
    end
  end
endmodule

// ---- bldc_speed_pi_loop_tb_top.sv ----
/*
  Self-checking bench for the speed loop with a host model beside it.
  Assumes shortened sample and edge-timeout counts and a 50 ns clock.
*/
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("mismatch at %0t got %h exp %h", $time, g, e); end end

module bldc_speed_pi_loop_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import bldc_pkg::*;

  typedef struct {
    logic signed [15:0] req;
    logic [15:0] kc;
    logic signed [11:0] exp;
  } case_row_s;

  case_row_s rows [6] = '{'{16'sh8, 16'h100, 12'sh8}, '{-16'sh8, 16'h100, -12'sh8},
    '{16'sh0, 16'h100, 12'sh0}, '{16'sh14, 16'h500, 12'sh64},
    '{16'shc8, 16'h100, 12'sh64}, '{-16'shc, 16'hffff, -12'sh3e8}};

  logic clk = 1'b0;
  logic rst = 1'b1;
  enc_pins_s enc = '0;
  logic overcurrent_pin = 1'b0;
  logic run_switch_pin = 1'b0;
  logic signed [15:0] speed_required = 16'sh0;
  pi_gains_s gains = '{kc: 16'h100, ki: 16'h0};
  logic start = 1'b0;
  logic [2:0] sector;
  logic commutate, host_pwm_off, align_req, cmp_load, pos_zero, aligned;
  logic [15:0] cmp_lo, cmp_hi, position;
  phase_drive_s drive;
  logic pos_irq, oc_irq, index_pulse, any_on;
  logic signed [15:0] speed_meas;
  logic signed [11:0] duty, d0;
  logic [1:0] q = 2'h0;
  int n_fail = 0;
  int checks = 0;
  int irq_cnt = 0;
  int idx_cnt = 0;
  int oc_cnt = 0;

  always #25 clk = ~clk;

  always @(posedge clk) begin
    if (pos_irq === 1'b1) irq_cnt++;
    if (index_pulse === 1'b1) idx_cnt++;
    if (oc_irq === 1'b1) oc_cnt++;
  end

  bldc_speed_pi_loop #(.SAMPLE_CYCLES(50), .EDGE_TIMEOUT(500)) dut (.clk(clk), .rst(rst), .enc(enc),
    .overcurrent_pin(overcurrent_pin), .run_switch_pin(run_switch_pin), .speed_required(speed_required),
    .gains(gains), .sector(sector), .commutate(commutate), .host_pwm_off(host_pwm_off),
    .align_req(align_req), .cmp_load(cmp_load), .pos_zero(pos_zero), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi),
    .drive(drive), .pos_irq(pos_irq), .oc_irq(oc_irq), .index_pulse(index_pulse), .position(position),
    .speed_meas(speed_meas), .duty(duty));

  bldc_host_model host (.clk(clk), .rst(rst), .start(start), .pos_irq(pos_irq), .oc_irq(oc_irq),
    .position(position), .sector(sector), .commutate(commutate), .host_pwm_off(host_pwm_off),
    .align_req(align_req), .cmp_load(cmp_load), .pos_zero(pos_zero), .cmp_lo(cmp_lo), .cmp_hi(cmp_hi),
    .aligned(aligned));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask

  // Gray steps on A/B, up for dir 1
  task automatic step(input int dir, input int n, input int gap);
    for (int k = 0; k < n; k++) begin
      q = q + 2'(dir);
      enc.a = q[1];
      enc.b = q[1] ^ q[0];
      tick(gap);
    end
  endtask

  task automatic finish_test(input string name);
    $display("test %s done", name);
  endtask

  task automatic close_out();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  initial begin
    #(30000 * 50);
    n_fail++;
    close_out();
  end

  initial begin
    tick(20);
    rst = 1'b0;
    tick(2);
    `CHK({drive, duty, position}, 34'h0)
    finish_test("reset");
    start = 1'b1;
    tick(60);
    `CHK(drive, 6'h00)
    run_switch_pin = 1'b1;
    tick(10);
    `CHK(drive.low_side, 3'b110)
    for (int k = 0; k < 300 && aligned !== 1'b1; k++) tick(1);
    `CHK(aligned, 1'b1)
    tick(2);
    `CHK(position, 16'h0)
    finish_test("align");
    step(1, 4, 8);
    `CHK(irq_cnt, 0)
    step(1, 1, 8);
    `CHK(irq_cnt, 1)
    `CHK(position, 16'h5)
    enc.idx = 1'b1;
    tick(6);
    enc.idx = 1'b0;
    tick(2);
    `CHK(idx_cnt, 1)
    finish_test("encoder");
    step(1, 20, 10);
    `CHK(speed_meas, 16'sh5)
    step(-1, 20, 10);
    `CHK(speed_meas, -16'sh5)
    step(2, 1, 8);
    `CHK(position, 16'h5)
    finish_test("speed");
    foreach (rows[i]) begin
      gains = '{kc: rows[i].kc, ki: 16'h0};
      speed_required = rows[i].req;
      tick(1600);
      `CHK(duty, rows[i].exp)
      finish_test("row");
    end
    `CHK(drive, 6'h0a)
    gains = '{kc: 16'h0, ki: 16'h100};
    speed_required = 16'sh4;
    tick(500);
    d0 = duty;
    tick(500);
    `CHK(12'(duty - d0), 12'sh28)
    finish_test("integral");
    run_switch_pin = 1'b0;
    tick(60);
    `CHK({drive, duty}, 18'h0)
    run_switch_pin = 1'b1;
    tick(500);
    finish_test("switch");
    overcurrent_pin = 1'b1;
    tick(5);
    any_on = 1'b0;
    for (int k = 0; k < 40; k++) begin
      if (k == 10) overcurrent_pin = 1'b0;
      any_on = any_on | (|drive);
      tick(1);
    end
    `CHK(any_on, 1'b0)
    `CHK(oc_cnt, 1)
    finish_test("overcurrent");
    close_out();
  end
endmodule
